// [design/cbdc_discard_timer.v]
// discard timer with a selectable long or short length
`timescale 1ns/1ps
module cbdc_discard_timer #(
   parameter CNT_W = 16,
   parameter LONG_LEN = 32768,
   parameter SHORT_LEN = 1024
) (
   input wire clk,
   input wire nrst,
   input wire run,
   input wire short_sel,
   output reg busy_q,
   output reg expired_q
);
   reg [CNT_W-1:0] cnt_q;
   reg done_q;
   wire [CNT_W-1:0] last;

   assign last = short_sel ? SHORT_LEN[CNT_W-1:0] - 1'b1 : LONG_LEN[CNT_W-1:0] - 1'b1;

   // one expiry per run; the timer rearms only when run drops
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= {CNT_W{1'b0}};
         done_q <= 1'b0;
         busy_q <= 1'b0;
         expired_q <= 1'b0;
      end else begin
         expired_q <= 1'b0;
         if (!run) begin
            cnt_q <= {CNT_W{1'b0}};
            done_q <= 1'b0;
            busy_q <= 1'b0;
         end else if (!done_q) begin
            busy_q <= 1'b1;
            if (cnt_q >= last) begin
               done_q <= 1'b1;
               busy_q <= 1'b0;
               expired_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule

// [design/cbdc_regs.v]
// device control and diagnostic register bank with an axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cbdc_defines.vh"
module cbdc_regs #(
   parameter ADDR_W = 12,
   parameter DISCARD_LONG = `CBDC_DISCARD_LONG,
   parameter DISCARD_SHORT = `CBDC_DISCARD_SHORT,
   parameter [15:0] VENDOR_ID = 16'h5a5a,
   parameter [15:0] DEVICE_ID = 16'ha5a5
) (
   input wire clk,
   input wire nrst,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire d3_state,
   input wire power_off_req,
   output reg power_off_go_q,
   output reg power_off_refused_q,
   output reg low_volt_socket_force_q,
   output reg diag_io_option_q,
   output reg bus_holder_en_q,
   output reg par_irq_en_q,
   output reg ser_irq_en_q,
   output reg par_bus_int_en_q,
   output reg ser_bus_int_en_q,
   input wire sock_int_route,
   input wire [3:0] scc_cfg_sel,
   output reg status_change_route_q,
   output reg status_change_async_on_q,
   output reg delayed_txn_off_q,
   input wire target_wait,
   output reg retry_now_q,
   input wire card_discard_run,
   input wire host_discard_run,
   output reg card_discard_expired_q,
   output reg host_discard_expired_q
);
   localparam CNT_W = 16;

   reg [7:0] device_control_q;
   reg [7:0] diagnostic_control_q;
   reg [ADDR_W-1:0] waddr_q;
   reg aw_hold_q;
   reg [7:0] wbyte_q;
   reg wen_q;
   reg w_hold_q;
   reg [ADDR_W-1:0] raddr_q;
   reg ar_hold_q;
   reg [6:0] lat_cnt_q;
   reg [31:0] rdata_d;
   reg rvalid_addr_ok;
   wire aw_take;
   wire w_take;
   wire ar_take;
   wire do_write;
   wire wr_devctl;
   wire wr_diag;
   wire waddr_ok;
   wire [1:0] irq_mode;
   wire [6:0] lat_last;
   wire card_busy;
   wire host_busy;
   wire card_exp;
   wire host_exp;

   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   assign wr_devctl = do_write & wen_q & (waddr_q == `CBDC_DEVCTL_ADDR);
   assign wr_diag = do_write & wen_q & (waddr_q == `CBDC_DIAG_ADDR);
   assign waddr_ok = (waddr_q == `CBDC_DEVCTL_ADDR) | (waddr_q == `CBDC_DIAG_ADDR) |
                     (waddr_q == `CBDC_ID_ADDR) | (waddr_q == `CBDC_STAT_ADDR);
   assign irq_mode = device_control_q[`CBDC_DC_IRQ_HI:`CBDC_DC_IRQ_LO];

   // write address and data are caught separately, in either order
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         waddr_q <= {ADDR_W{1'b0}};
         wbyte_q <= 8'h00;
         wen_q <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CBDC_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_hold_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (w_take) begin
            w_hold_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            // only the low byte lane carries register bits
            wen_q <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (!w_hold_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= waddr_ok ? `CBDC_RESP_OKAY : `CBDC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CBDC_RESP_OKAY;
         end
      end
   end

   // the registers themselves
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         device_control_q <= `CBDC_DEVCTL_RST;
         diagnostic_control_q <= `CBDC_DIAG_RST;
      end else begin
         // test bits 3 and 0 are stored as written; software keeps them at 0
         if (wr_devctl) begin
            device_control_q <= wbyte_q;
         end
         if (wr_diag) begin
            diagnostic_control_q <= wbyte_q;
            diagnostic_control_q[`CBDC_DG_RSVD] <= 1'b0;
         end
      end
   end

   // read channel: answer one edge after the address is taken
   always @* begin
      rdata_d = 32'h0000_0000;
      rvalid_addr_ok = 1'b1;
      case (raddr_q)
         `CBDC_DEVCTL_ADDR: begin
            rdata_d = {24'h000000, device_control_q};
         end
         `CBDC_DIAG_ADDR: begin
            rdata_d = {24'h000000, diagnostic_control_q};
            rdata_d[`CBDC_DG_RSVD] = 1'b0;
         end
         `CBDC_ID_ADDR: begin
            if (diagnostic_control_q[`CBDC_DG_ID_MASK]) begin
               rdata_d = 32'hffff_ffff;
            end else begin
               rdata_d = {DEVICE_ID, VENDOR_ID};
            end
         end
         `CBDC_STAT_ADDR: begin
            rdata_d = {26'h0000000, lat_cnt_q != 7'd0, host_busy, card_busy,
                       status_change_route_q, d3_state,
                       device_control_q[`CBDC_DC_PWR_HOLD] & d3_state};
         end
         default: begin
            rvalid_addr_ok = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         ar_hold_q <= 1'b0;
         raddr_q <= {ADDR_W{1'b0}};
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CBDC_RESP_OKAY;
      end else begin
         if (ar_take) begin
            ar_hold_q <= 1'b1;
            raddr_q <= s_axi_araddr;
            s_axi_arready <= 1'b0;
         end else if (ar_hold_q && !s_axi_rvalid) begin
            ar_hold_q <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rvalid_addr_ok ? `CBDC_RESP_OKAY : `CBDC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CBDC_RESP_OKAY;
         end else if (!ar_hold_q && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // socket power: a lock keeps the card powered for wake events in D3
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_off_go_q <= 1'b0;
         power_off_refused_q <= 1'b0;
      end else begin
         if (power_off_req && device_control_q[`CBDC_DC_PWR_HOLD] && d3_state) begin
            power_off_go_q <= 1'b0;
            power_off_refused_q <= 1'b1;
         end else begin
            power_off_go_q <= power_off_req;
            power_off_refused_q <= 1'b0;
         end
      end
   end

   // control decodes, registered so every output comes from a flop
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_volt_socket_force_q <= 1'b0;
         diag_io_option_q <= 1'b0;
         bus_holder_en_q <= 1'b0;
         par_irq_en_q <= 1'b0;
         ser_irq_en_q <= 1'b0;
         par_bus_int_en_q <= 1'b0;
         ser_bus_int_en_q <= 1'b0;
         status_change_route_q <= 1'b0;
         status_change_async_on_q <= 1'b0;
         delayed_txn_off_q <= 1'b0;
      end else begin
         low_volt_socket_force_q <= device_control_q[`CBDC_DC_LV_FORCE];
         diag_io_option_q <= device_control_q[`CBDC_DC_IO_OPT];
         bus_holder_en_q <= device_control_q[`CBDC_DC_BUS_HOLD];
         case (irq_mode)
            `CBDC_IRQ_PAR_BUS: begin
               par_irq_en_q <= 1'b0;
               ser_irq_en_q <= 1'b0;
               par_bus_int_en_q <= 1'b1;
               ser_bus_int_en_q <= 1'b0;
            end
            `CBDC_IRQ_PAR_BOTH: begin
               par_irq_en_q <= 1'b1;
               ser_irq_en_q <= 1'b0;
               par_bus_int_en_q <= 1'b1;
               ser_bus_int_en_q <= 1'b0;
            end
            `CBDC_IRQ_SER_IRQ: begin
               par_irq_en_q <= 1'b0;
               ser_irq_en_q <= 1'b1;
               par_bus_int_en_q <= 1'b1;
               ser_bus_int_en_q <= 1'b0;
            end
            default: begin
               par_irq_en_q <= 1'b0;
               ser_irq_en_q <= 1'b1;
               par_bus_int_en_q <= 1'b0;
               ser_bus_int_en_q <= 1'b1;
            end
         endcase
         // with the new routing the older per-socket bit is a don't care
         if (diagnostic_control_q[`CBDC_DG_SCC_ROUTE]) begin
            status_change_route_q <= (scc_cfg_sel == 4'h0);
         end else begin
            status_change_route_q <= sock_int_route;
         end
         status_change_async_on_q <= diagnostic_control_q[`CBDC_DG_ASYNC];
         delayed_txn_off_q <= diagnostic_control_q[`CBDC_DG_DLY_OFF];
      end
   end

   // retry latency: a target that cannot answer in time is retried
   assign lat_last = diagnostic_control_q[`CBDC_DG_LAT_EXT] ?
                     `CBDC_RETRY_LAT_LONG - 7'd1 : `CBDC_RETRY_LAT_SHORT - 7'd1;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lat_cnt_q <= 7'd0;
         retry_now_q <= 1'b0;
      end else begin
         retry_now_q <= 1'b0;
         if (!target_wait) begin
            lat_cnt_q <= 7'd0;
         end else if (lat_cnt_q >= lat_last) begin
            lat_cnt_q <= 7'd0;
            retry_now_q <= 1'b1;
         end else begin
            lat_cnt_q <= lat_cnt_q + 7'd1;
         end
      end
   end

   // discard timers for the card side and the host side
   cbdc_discard_timer #(
      .CNT_W(CNT_W),
      .LONG_LEN(DISCARD_LONG),
      .SHORT_LEN(DISCARD_SHORT)
   ) u_card_discard (
      .clk(clk),
      .nrst(nrst),
      .run(card_discard_run),
      .short_sel(diagnostic_control_q[`CBDC_DG_DISC_CARD]),
      .busy_q(card_busy),
      .expired_q(card_exp)
   );

   cbdc_discard_timer #(
      .CNT_W(CNT_W),
      .LONG_LEN(DISCARD_LONG),
      .SHORT_LEN(DISCARD_SHORT)
   ) u_host_discard (
      .clk(clk),
      .nrst(nrst),
      .run(host_discard_run),
      .short_sel(diagnostic_control_q[`CBDC_DG_DISC_HOST]),
      .busy_q(host_busy),
      .expired_q(host_exp)
   );

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         card_discard_expired_q <= 1'b0;
         host_discard_expired_q <= 1'b0;
      end else begin
         card_discard_expired_q <= card_exp;
         host_discard_expired_q <= host_exp;
      end
   end
endmodule

// [dv/cbdc_regs_assertions.sv]
// checker for the card bridge control register bank
`timescale 1ns/1ps
module cbdc_regs_assertions (
   input wire clk,
   input wire nrst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire d3_state,
   input wire power_off_req,
   input wire power_off_go_q,
   input wire power_off_refused_q,
   input wire low_volt_socket_force_q,
   input wire diag_io_option_q,
   input wire bus_holder_en_q,
   input wire par_irq_en_q,
   input wire ser_irq_en_q,
   input wire par_bus_int_en_q,
   input wire ser_bus_int_en_q,
   input wire status_change_async_on_q,
   input wire delayed_txn_off_q,
   input wire target_wait,
   input wire retry_now_q
);
   // saturates so a long wait never wraps into a false early count
   logic [6:0] wait_cnt_q;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) wait_cnt_q <= 7'h00;
      else if (!target_wait) wait_cnt_q <= 7'h00;
      else if (wait_cnt_q != 7'h7f) wait_cnt_q <= wait_cnt_q + 7'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   pwr_grant_a: assert property (
      power_off_req && !d3_state |=> power_off_go_q && !power_off_refused_q)
      else $error("power-off outside low-power state not granted");
   pwr_refuse_a: assert property (
      power_off_refused_q |-> $past(power_off_req) && $past(d3_state) && !power_off_go_q)
      else $error("power-off refused without cause");
   irq_ser_a: assert property (
      ser_bus_int_en_q |-> ser_irq_en_q && !par_irq_en_q && !par_bus_int_en_q)
      else $error("serialized mode decode wrong");
   irq_par_a: assert property (
      par_irq_en_q |-> par_bus_int_en_q && !ser_irq_en_q && !ser_bus_int_en_q)
      else $error("parallel mode decode wrong");
   retry_len_a: assert property (
      retry_now_q |-> wait_cnt_q >= 7'd16)
      else $error("retry fired too early");
   retry_clr_a: assert property (
      !target_wait |=> !retry_now_q)
      else $error("retry fired without a waiting target");
   rd_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready
         ##1 s_axi_bvalid && !s_axi_awready)
      else $error("write answer or address block wrong");
   rst_dflt_a: assert property (
      $rose(nrst) |=> low_volt_socket_force_q && diag_io_option_q && !bus_holder_en_q
         && status_change_async_on_q && !delayed_txn_off_q)
      else $error("outputs not at reset defaults");
endmodule

// [dv/cbdc_regs_tb_top.sv]
// self-checking bench for the card bridge control register bank
`timescale 1ns/1ps
`include "cbdc_defines.vh"
module cbdc_regs_tb_top;
   logic clk = 1'b0, nrst = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, rdat;
   logic d3_state = 1'b0, power_off_req = 1'b0, sock_int_route = 1'b0, target_wait = 1'b0;
   logic card_discard_run = 1'b0, host_discard_run = 1'b0;
   logic [3:0] scc_cfg_sel = 4'h0;
   logic [1:0] rsp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire power_off_go_q, power_off_refused_q, low_volt_socket_force_q, diag_io_option_q;
   wire bus_holder_en_q, par_irq_en_q, ser_irq_en_q, par_bus_int_en_q, ser_bus_int_en_q;
   wire status_change_route_q, status_change_async_on_q, delayed_txn_off_q, retry_now_q;
   wire card_discard_expired_q, host_discard_expired_q;
   int mismatches = 0, comparisons = 0;
   // short timer lengths keep the run brief; expectations use the same values
   cbdc_regs #(.DISCARD_LONG(64), .DISCARD_SHORT(16)) u_dut (
      .clk, .nrst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .d3_state,
      .power_off_req, .power_off_go_q, .power_off_refused_q, .low_volt_socket_force_q,
      .diag_io_option_q, .bus_holder_en_q, .par_irq_en_q, .ser_irq_en_q, .par_bus_int_en_q,
      .ser_bus_int_en_q, .sock_int_route, .scc_cfg_sel, .status_change_route_q,
      .status_change_async_on_q, .delayed_txn_off_q, .target_wait, .retry_now_q,
      .card_discard_run, .host_discard_run, .card_discard_expired_q, .host_discard_expired_q);
   initial begin
      forever #5 clk = ~clk;
   end
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #300000;
      mismatches++;
      end_of_test;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // the trailing edge lets decoded outputs follow the register before checks
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
   endtask
   task pwr(input logic d3, input logic [1:0] e);
      @(posedge clk);
      d3_state <= d3;
      power_off_req <= 1'b1;
      @(posedge clk);
      power_off_req <= 1'b0;
      #1 chk({power_off_go_q, power_off_refused_q}, e);
   endtask
   task route(input logic s, input logic [3:0] c, input logic e);
      @(posedge clk);
      sock_int_route <= s;
      scc_cfg_sel <= c;
      repeat (2) @(posedge clk);
      #1 chk(status_change_route_q, e);
   endtask
   task retry(input int n);
      int k;
      @(posedge clk);
      target_wait <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (retry_now_q !== 1'b1 && k < 100);
      target_wait <= 1'b0;
      chk(k, n + 1);
   endtask
   // expiry shows two edges after the last count: timer flop, then output flop
   task disc(input logic card, input int len);
      int k;
      @(posedge clk);
      card_discard_run <= card;
      host_discard_run <= !card;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((card ? card_discard_expired_q : host_discard_expired_q) !== 1'b1 && k < 200);
      card_discard_run <= 1'b0;
      host_discard_run <= 1'b0;
      chk(k, len + 2);
   endtask
   task t_defaults;
      rd(`CBDC_DEVCTL_ADDR, 32'h66);
      rd(`CBDC_DIAG_ADDR, 32'h21);
      chk(rsp, `CBDC_RESP_OKAY);
      chk({low_volt_socket_force_q, diag_io_option_q, bus_holder_en_q, par_irq_en_q,
         ser_irq_en_q, par_bus_int_en_q, ser_bus_int_en_q, status_change_async_on_q,
         delayed_txn_off_q}, 9'h196);
   endtask
   task t_modes;
      int m;
      for (m = 0; m < 4; m++) begin
         wr(`CBDC_DEVCTL_ADDR, 8'h10 | (m[7:0] << 1));
         chk(rsp, `CBDC_RESP_OKAY);
         chk({low_volt_socket_force_q, bus_holder_en_q, par_irq_en_q, ser_irq_en_q,
            par_bus_int_en_q, ser_bus_int_en_q}, {2'h1, m == 1, m[1], m != 3, m == 3});
      end
   endtask
   task t_regs;
      wr(`CBDC_DIAG_ADDR, 8'hff);
      rd(`CBDC_DIAG_ADDR, 32'hbf);
      rd(`CBDC_ID_ADDR, 32'hffffffff);
      chk({delayed_txn_off_q, status_change_async_on_q}, 2'h3);
      wr(`CBDC_DIAG_ADDR, 8'h00);
      rd(`CBDC_ID_ADDR, 32'ha5a55a5a);
      chk({delayed_txn_off_q, status_change_async_on_q}, 2'h0);
      wr(12'h100, 8'h01);
      chk(rsp, 2'h2);
      rd(12'h100, 32'h0);
      chk(rsp, 2'h2);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      t_defaults;
      t_modes;
      t_regs;
      wr(`CBDC_DEVCTL_ADDR, 8'h80);
      pwr(1'b1, 2'h1);
      rd(`CBDC_STAT_ADDR, 32'h3);
      pwr(1'b0, 2'h2);
      wr(`CBDC_DEVCTL_ADDR, 8'h00);
      pwr(1'b1, 2'h2);
      route(1'b1, 4'h5, 1'b1);
      route(1'b0, 4'h0, 1'b0);
      wr(`CBDC_DIAG_ADDR, 8'h20);
      route(1'b0, 4'h0, 1'b1);
      route(1'b1, 4'h8, 1'b0);
      retry(16);
      wr(`CBDC_DIAG_ADDR, 8'h0c);
      retry(64);
      disc(1'b1, 16);
      disc(1'b0, 64);
      wr(`CBDC_DIAG_ADDR, 8'h02);
      disc(1'b1, 64);
      disc(1'b0, 16);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(`CBDC_DEVCTL_ADDR, 32'h66);
      rd(`CBDC_DIAG_ADDR, 32'h21);
      end_of_test;
   end
endmodule
bind cbdc_regs cbdc_regs_assertions u_chk (.clk, .nrst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .d3_state, .power_off_req,
   .power_off_go_q, .power_off_refused_q, .low_volt_socket_force_q, .diag_io_option_q,
   .bus_holder_en_q, .par_irq_en_q, .ser_irq_en_q, .par_bus_int_en_q, .ser_bus_int_en_q,
   .status_change_async_on_q, .delayed_txn_off_q, .target_wait, .retry_now_q);

// [pkg/cbdc_defines.vh]
// constants for the card bridge device control register bank
`ifndef CBDC_DEFINES_VH
`define CBDC_DEFINES_VH

// register indices; the byte address is four times the index
`define CBDC_DEVCTL_IDX 8'h92
`define CBDC_DIAG_IDX 8'h93
`define CBDC_ID_IDX 8'hc0
`define CBDC_STAT_IDX 8'hc1
`define CBDC_DEVCTL_ADDR ({2'b00, `CBDC_DEVCTL_IDX, 2'b00})
`define CBDC_DIAG_ADDR ({2'b00, `CBDC_DIAG_IDX, 2'b00})
`define CBDC_ID_ADDR ({2'b00, `CBDC_ID_IDX, 2'b00})
`define CBDC_STAT_ADDR ({2'b00, `CBDC_STAT_IDX, 2'b00})

// reset values
`define CBDC_DEVCTL_RST 8'h66
`define CBDC_DIAG_RST 8'h21

// device control fields
`define CBDC_DC_PWR_HOLD 7
`define CBDC_DC_LV_FORCE 6
`define CBDC_DC_IO_OPT 5
`define CBDC_DC_BUS_HOLD 4
`define CBDC_DC_VTEST 3
`define CBDC_DC_IRQ_HI 2
`define CBDC_DC_IRQ_LO 1
`define CBDC_DC_RTEST 0

// diagnostic fields
`define CBDC_DG_ID_MASK 7
`define CBDC_DG_RSVD 6
`define CBDC_DG_SCC_ROUTE 5
`define CBDC_DG_DLY_OFF 4
`define CBDC_DG_LAT_EXT 3
`define CBDC_DG_DISC_CARD 2
`define CBDC_DG_DISC_HOST 1
`define CBDC_DG_ASYNC 0

// interrupt signalling modes
`define CBDC_IRQ_PAR_BUS 2'b00
`define CBDC_IRQ_PAR_BOTH 2'b01
`define CBDC_IRQ_SER_IRQ 2'b10
`define CBDC_IRQ_SER_BOTH 2'b11

// timing counts in clock cycles
`define CBDC_RETRY_LAT_SHORT 7'd16
`define CBDC_RETRY_LAT_LONG 7'd64
`define CBDC_DISCARD_SHORT 1024
`define CBDC_DISCARD_LONG 32768

// bus answers
`define CBDC_RESP_OKAY 2'b00
`define CBDC_RESP_SLVERR 2'b10

`endif
